// ---- include/gdw_pkg.sv ----
// Package: command word layout, register codes and reset values
`default_nettype none

package gdw_pkg;

	// ****************************************
	// Sizes
	// ****************************************
	localparam int unsigned WORD_W = 16;
	localparam int unsigned DATA_W = 12;
	localparam int unsigned NCH = 8;
	localparam int unsigned CNT_W = 5;
	localparam logic [4:0] BITS_PER_WORD = 5'h10;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int unsigned CMD_DAC_BIT = 15;
	localparam int unsigned REG_ADDR_HI = 14;
	localparam int unsigned REG_ADDR_LO = 11;
	localparam int unsigned DAC_CH_HI = 14;
	localparam int unsigned DAC_CH_LO = 12;
	localparam int unsigned BIT_PRECHG = 9;
	localparam int unsigned BIT_BUF_EN = 8;
	localparam int unsigned BIT_LOCK = 7;
	localparam int unsigned BIT_ALL_DAC = 6;
	localparam int unsigned BIT_ADC_RNG = 5;
	localparam int unsigned BIT_DAC_RNG = 4;
	localparam logic [15:0] GP_CTL_MASK = 16'h03f0;

	// ****************************************
	// Register addresses
	// ****************************************
	localparam logic [3:0] ADDR_GP_CTL = 4'h3;
	localparam logic [3:0] ADDR_ADC_CFG = 4'h4;
	localparam logic [3:0] ADDR_DAC_CFG = 4'h5;
	localparam logic [3:0] ADDR_PD_CFG = 4'h6;
	localparam logic [3:0] ADDR_LOAD = 4'h7;
	localparam logic [3:0] ADDR_GPO_CFG = 4'h8;
	localparam logic [3:0] ADDR_GPI_CFG = 4'ha;
	localparam logic [3:0] ADDR_OD_CFG = 4'hc;
	localparam logic [3:0] ADDR_TRI_CFG = 4'hd;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [15:0] GP_CTL_RST = 16'h0000;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [7:0] PD_CFG_RST = 8'hff;
	localparam logic [11:0] DAC_RST = 12'h000;

	// ****************************************
	// Output load modes
	// ****************************************
	typedef enum logic [1:0] {
		LOAD_AUTO = 2'b00,
		LOAD_HOLD = 2'b01,
		LOAD_ALL = 2'b10
	} gdw_load_t;

endpackage : gdw_pkg

`default_nettype wire

// ---- core/gdw_spi_rx.sv ----
// Serial word receiver on the link clock, handing words over by toggle
`default_nettype none

module gdw_spi_rx (
	// Reset from the system domain, released while the link is idle
	input wire logic rst_i,
	// Link pins
	input wire logic spi_sclk_i,
	input wire logic spi_sync_n_i,
	input wire logic spi_sdi_i,
	// Received word
	output logic [15:0] word_o,
	output logic word_tgl_o
);

	import gdw_pkg::*;

	typedef struct packed {
		logic [4:0] cnt;
		logic [15:0] shift;
		logic [15:0] word;
		logic tgl;
	} gdw_rx_t;

	gdw_rx_t q, d;

	// ****************************************
	// Shift and hand-over
	// ****************************************
	// Bits beyond the sixteenth are dropped; the word stays put until the next
	// frame completes, so the other domain can sample it after the toggle.
	always_comb begin
		d = q;
		if (q.cnt != BITS_PER_WORD) begin
			d.shift = {q.shift[14:0], spi_sdi_i};
			d.cnt = q.cnt + 5'h01;
			if (q.cnt == BITS_PER_WORD - 5'h01) begin
				d.word = {q.shift[14:0], spi_sdi_i};
				d.tgl = ~q.tgl;
			end
		end
	end

	// The clock stops between frames, so the frame signal restarts the count.
	// The toggle is reset with the other side, or a false word follows reset.
	always_ff @(negedge spi_sclk_i or posedge spi_sync_n_i or posedge rst_i) begin
		if (rst_i) begin
			q <= '0;
		end else if (spi_sync_n_i) begin
			q.cnt <= 5'h00;
		end else begin
			q <= d;
		end
	end

	assign word_o = q.word;
	assign word_tgl_o = q.tgl;

endmodule : gdw_spi_rx

`default_nettype wire

// ---- core/gdw_ctrl.sv ----
// Command decoder: general control, pin setup and DAC data registers
`default_nettype none

// Summary of operation
// R1: A word with top bit clear and address 0011 writes the general control register.
// R2: The ADC range bit picks a span of one or two times the reference, one at reset.
// R3: The DAC range bit picks the span of every DAC channel, one reference at reset.
// R4: The ADC buffer enable bit powers the input buffer when set and is clear at reset.
// R5: With precharge clear an enabled buffer stays powered all the time.
// R6: With precharge set an enabled buffer is powered only while a conversion runs.
// R7: While lock is set, writes to the pin setup registers are dropped; lock resets clear.
// R8: While broadcast is set, DAC writes load every channel that is set up as a DAC.
// R9: While broadcast is clear, a DAC write loads only its addressed channel.
// R10: The host writes zero to the reserved control bits 10 and 3 to 0.
// R11: A word with its top bit set is a DAC data write.
// R12: A DAC write carries a channel in bits 14 to 12 and a code in bits 11 to 0.
// R13: A DAC write lands first in the channel input register, apart from the output.
// R14: Moving input registers to the outputs follows the current load mode.
// R15: The host sets a pin up as a DAC before writing its data.
// R16: Load mode 00 copies at once, 01 holds, 10 moves all and keeps the old mode.
// R17: Control fields hold until rewritten or reset and read as zero after reset.
module gdw_ctrl (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Serial link
	input wire logic spi_sclk_i,
	input wire logic spi_sync_n_i,
	input wire logic spi_sdi_i,
	// ADC sequencer
	input wire logic conv_active_i,
	// Control view
	output logic [15:0] gp_ctl_o,
	output logic adc_range_o,
	output logic dac_range_o,
	output logic adc_buf_pwr_o,
	output logic cfg_lock_o,
	output logic dac_all_o,
	output logic [1:0] load_mode_o,
	// Pin setup
	output logic [7:0] adc_pin_o,
	output logic [7:0] dac_pin_o,
	output logic [7:0] pd_pin_o,
	output logic [7:0] gpo_pin_o,
	output logic [7:0] gpi_pin_o,
	output logic [7:0] od_pin_o,
	output logic [7:0] tri_pin_o,
	// DAC channels
	output logic [95:0] dac_in_o,
	output logic [95:0] dac_code_o,
	output logic [7:0] dac_upd_o
);

	import gdw_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic sync1;
		logic sync2;
		logic sync3;
		logic [15:0] gp_ctl;
		logic [7:0] adc_cfg;
		logic [7:0] dac_cfg;
		logic [7:0] pd_cfg;
		logic [7:0] gpo_cfg;
		logic [7:0] gpi_cfg;
		logic [7:0] od_cfg;
		logic [7:0] tri_cfg;
		logic [1:0] load_mode;
		logic buf_pwr;
		logic [7:0][11:0] in_reg;
		logic [7:0][11:0] out_reg;
		logic [7:0] upd;
	} gdw_state_t;

	gdw_state_t q_q, q_d;

	logic [15:0] rx_word;
	logic rx_tgl;

	// ****************************************
	// Link side receiver
	// ****************************************
	gdw_spi_rx u_rx (
		.rst_i(sys_rst_i),
		.spi_sclk_i(spi_sclk_i),
		.spi_sync_n_i(spi_sync_n_i),
		.spi_sdi_i(spi_sdi_i),
		.word_o(rx_word),
		.word_tgl_o(rx_tgl)
	);

	// ****************************************
	// Decode helpers
	// ****************************************
	logic word_new;
	logic is_dac_wr;
	logic [3:0] reg_addr;
	logic [2:0] dac_ch;
	logic [11:0] dac_data;
	logic cfg_wr_ok;

	// Word is stable long before the toggle reaches sync3, so it is safe here
	assign word_new = q_q.sync2 ^ q_q.sync3;
	assign is_dac_wr = rx_word[CMD_DAC_BIT]; // R11
	assign reg_addr = rx_word[REG_ADDR_HI:REG_ADDR_LO];
	assign dac_ch = rx_word[DAC_CH_HI:DAC_CH_LO]; // R12
	assign dac_data = rx_word[DATA_W-1:0]; // R12
	assign cfg_wr_ok = word_new & ~is_dac_wr & ~q_q.gp_ctl[BIT_LOCK]; // R7

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic sel;
		sel = 1'b0;
		q_d = q_q;
		q_d.upd = 8'h00;

		// Toggle crossing from the link clock
		q_d.sync1 = rx_tgl;
		q_d.sync2 = q_q.sync1;
		q_d.sync3 = q_q.sync2;

		// General control; reserved bits are masked off so they read as zero
		if (word_new && !is_dac_wr && reg_addr == ADDR_GP_CTL) begin // R1
			q_d.gp_ctl = rx_word & GP_CTL_MASK; // R10 R17
		end

		// Pin setup registers, frozen while locked
		if (cfg_wr_ok) begin
			unique case (reg_addr)
				ADDR_ADC_CFG: begin
					q_d.adc_cfg = rx_word[7:0]; // R7
				end
				ADDR_DAC_CFG: begin
					q_d.dac_cfg = rx_word[7:0]; // R7
				end
				ADDR_PD_CFG: begin
					q_d.pd_cfg = rx_word[7:0]; // R7
				end
				ADDR_GPO_CFG: begin
					q_d.gpo_cfg = rx_word[7:0]; // R7
				end
				ADDR_GPI_CFG: begin
					q_d.gpi_cfg = rx_word[7:0]; // R7
				end
				ADDR_OD_CFG: begin
					q_d.od_cfg = rx_word[7:0]; // R7
				end
				ADDR_TRI_CFG: begin
					q_d.tri_cfg = rx_word[7:0]; // R7
				end
				default: begin
				end
			endcase
		end

		// Load mode; a move-all request acts once and leaves the mode as it was
		if (word_new && !is_dac_wr && reg_addr == ADDR_LOAD) begin
			unique case (rx_word[1:0])
				LOAD_ALL: begin
					q_d.out_reg = q_q.in_reg; // R16
					q_d.upd = 8'hff; // R16
				end
				LOAD_AUTO, LOAD_HOLD: begin
					q_d.load_mode = rx_word[1:0]; // R16
				end
				default: begin
					// Code 11 has no meaning and is ignored
				end
			endcase
		end

		// DAC data write
		if (word_new && is_dac_wr) begin // R11
			for (int i = 0; i < NCH; i++) begin
				if (q_q.gp_ctl[BIT_ALL_DAC]) begin
					sel = q_q.dac_cfg[i]; // R8
				end else begin
					sel = (dac_ch == 3'(i)); // R9
				end
				if (sel) begin
					q_d.in_reg[i] = dac_data; // R13
					if (q_q.load_mode == LOAD_AUTO) begin // R14
						q_d.out_reg[i] = dac_data; // R16
						q_d.upd[i] = 1'b1;
					end
				end
			end
		end

		// Buffer power follows the enable, gated to conversions in precharge
		if (!q_q.gp_ctl[BIT_BUF_EN]) begin
			q_d.buf_pwr = 1'b0; // R4
		end else if (!q_q.gp_ctl[BIT_PRECHG]) begin
			q_d.buf_pwr = 1'b1; // R5
		end else begin
			q_d.buf_pwr = conv_active_i; // R6
		end

		if (sys_rst_i) begin
			q_d.sync1 = 1'b0;
			q_d.sync2 = 1'b0;
			q_d.sync3 = 1'b0;
			q_d.gp_ctl = GP_CTL_RST; // R17
			q_d.adc_cfg = CFG_RST;
			q_d.dac_cfg = CFG_RST;
			q_d.pd_cfg = PD_CFG_RST;
			q_d.gpo_cfg = CFG_RST;
			q_d.gpi_cfg = CFG_RST;
			q_d.od_cfg = CFG_RST;
			q_d.tri_cfg = CFG_RST;
			q_d.load_mode = LOAD_AUTO;
			q_d.buf_pwr = 1'b0;
			q_d.in_reg = {NCH{DAC_RST}};
			q_d.out_reg = {NCH{DAC_RST}};
			q_d.upd = 8'h00;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk_i) begin
		q_q <= q_d;
	end

	// ****************************************
	// Outputs
	// ****************************************
	// All outputs are register fields; buffer power lags its cause by a cycle
	assign gp_ctl_o = q_q.gp_ctl;
	assign adc_range_o = q_q.gp_ctl[BIT_ADC_RNG]; // R2
	assign dac_range_o = q_q.gp_ctl[BIT_DAC_RNG]; // R3
	assign adc_buf_pwr_o = q_q.buf_pwr;
	assign cfg_lock_o = q_q.gp_ctl[BIT_LOCK];
	assign dac_all_o = q_q.gp_ctl[BIT_ALL_DAC];
	assign load_mode_o = q_q.load_mode;
	assign adc_pin_o = q_q.adc_cfg;
	assign dac_pin_o = q_q.dac_cfg;
	assign pd_pin_o = q_q.pd_cfg;
	assign gpo_pin_o = q_q.gpo_cfg;
	assign gpi_pin_o = q_q.gpi_cfg;
	assign od_pin_o = q_q.od_cfg;
	assign tri_pin_o = q_q.tri_cfg;
	assign dac_in_o = q_q.in_reg;
	assign dac_code_o = q_q.out_reg;
	assign dac_upd_o = q_q.upd;

endmodule : gdw_ctrl

`default_nettype wire

// ---- bench/gdw_host.sv ----
// Host model that sends one command word per frame
`default_nettype none
module gdw_host (
	// Link pins
	output logic sclk_o,
	output logic sync_n_o,
	output logic sdi_o
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		sclk_o = 1'b0;
		sync_n_o = 1'b1;
		sdi_o = 1'b1;
	end
	// Clock stands still outside a frame; data flips when idle so stale bits never match
	// Data moves on the rising edge so it is settled at the sampling falling edge
	task automatic send(input logic [15:0] w, input int n);
		sync_n_o = 1'b0;
		for (int i = 15; i > 15 - n; i--) begin
			#3 sclk_o = 1'b1;
			sdi_o = w[i];
			#3 sclk_o = 1'b0;
		end
		#3 sync_n_o = 1'b1;
		sdi_o = ~w[0];
	endtask : send
endmodule : gdw_host
`default_nettype wire

// ---- bench/gdw_ctrl_chk.sv ----
// Assertions on the control decoder ports
`default_nettype none
module gdw_ctrl_chk
	import gdw_pkg::*;
(
	// Clock and inputs
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic conv_active_i,
	// Outputs watched
	input wire logic [15:0] gp_ctl_o,
	input wire logic adc_range_o,
	input wire logic dac_range_o,
	input wire logic adc_buf_pwr_o,
	input wire logic cfg_lock_o,
	input wire logic dac_all_o,
	input wire logic [1:0] load_mode_o,
	input wire logic [7:0] dac_pin_o,
	input wire logic [7:0] pd_pin_o,
	input wire logic [95:0] dac_in_o,
	input wire logic [95:0] dac_code_o,
	input wire logic [7:0] dac_upd_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	a_rst_values: assert property (disable iff (1'b0) $past(sys_rst_i) |->
		gp_ctl_o == GP_CTL_RST && pd_pin_o == PD_CFG_RST && dac_code_o == '0)
		else $error("Reset values wrong");
	a_field_view: assert property ((gp_ctl_o & ~GP_CTL_MASK) == '0 &&
		{adc_range_o, dac_range_o, cfg_lock_o, dac_all_o} == {gp_ctl_o[5:4], gp_ctl_o[7:6]})
		else $error("Control fields disagree");
	a_buf_power: assert property ($stable(gp_ctl_o) && $stable(conv_active_i) |->
		adc_buf_pwr_o == (gp_ctl_o[8] & (~gp_ctl_o[9] | conv_active_i)))
		else $error("Buffer power wrong");
	sequence s_upd_any;
		|dac_upd_o;
	endsequence
	sequence s_upd_none;
		dac_upd_o == 8'h00;
	endsequence
	a_upd_pulse: assert property (s_upd_any |=> s_upd_none)
		else $error("Update pulse too long");
	a_code_upd: assert property ($changed(dac_code_o) |-> |dac_upd_o)
		else $error("Output changed without update");
	a_hold_keeps: assert property (load_mode_o == 2'b01 && $stable(load_mode_o) |->
		$stable(dac_code_o) || dac_upd_o == 8'hff) else $error("Hold mode leaked");
	a_auto_copy: assert property (load_mode_o == 2'b00 && $changed(dac_in_o) |->
		$changed(dac_code_o) && |dac_upd_o) else $error("Auto mode did not copy");
	a_lock_holds: assert property (cfg_lock_o && $past(cfg_lock_o) |->
		$stable(dac_pin_o) && $stable(pd_pin_o)) else $error("Locked setup changed");
	a_mode_legal: assert property (load_mode_o[1] == 1'b0)
		else $error("Load mode illegal");
	a_bcast_pins: assert property (dac_all_o && $changed(dac_in_o) |->
		(dac_upd_o & ~dac_pin_o) == 8'h00) else $error("Broadcast hit non DAC pin");
endmodule : gdw_ctrl_chk
bind gdw_ctrl gdw_ctrl_chk gdw_ctrl_chk_i (.*);
`default_nettype wire

// ---- bench/test_general_control_and_dac_write.sv ----
// Self-checking bench for the control decoder
`default_nettype none
`define CK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module test_general_control_and_dac_write;
	timeunit 1ns;
	timeprecision 100ps;
	import gdw_pkg::*;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b0;
	logic conv_active_i = 1'b0;
	logic sclk, sync_n, sdi, adc_range_o, dac_range_o, adc_buf_pwr_o;
	logic [1:0] load_mode_o;
	logic [7:0] dac_pin_o, pd_pin_o, adc_pin_o, gpo_pin_o, gpi_pin_o, od_pin_o, tri_pin_o;
	logic [15:0] gp_ctl_o;
	logic [95:0] dac_in_o, dac_code_o;
	int fails = 0;
	int n_compared = 0;
	always #12.5 clk_i = ~clk_i;
	gdw_host gdw_host_i (.sclk_o(sclk), .sync_n_o(sync_n), .sdi_o(sdi));
	gdw_ctrl gdw_ctrl_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .spi_sclk_i(sclk),
		.spi_sync_n_i(sync_n), .spi_sdi_i(sdi), .conv_active_i(conv_active_i),
		.gp_ctl_o(gp_ctl_o), .adc_range_o(adc_range_o), .dac_range_o(dac_range_o),
		.adc_buf_pwr_o(adc_buf_pwr_o), .cfg_lock_o(), .dac_all_o(), .load_mode_o(load_mode_o),
		.adc_pin_o(adc_pin_o), .dac_pin_o(dac_pin_o), .pd_pin_o(pd_pin_o),
		.gpo_pin_o(gpo_pin_o), .gpi_pin_o(gpi_pin_o), .od_pin_o(od_pin_o),
		.tri_pin_o(tri_pin_o), .dac_in_o(dac_in_o), .dac_code_o(dac_code_o), .dac_upd_o());
	// Ten cycles covers the answer latency and the spacing between words
	task automatic wr(input logic [15:0] w, input int n = 16);
		gdw_host_i.send(w, n);
		repeat (10) @(posedge clk_i);
		#2;
	endtask : wr
	function automatic logic [11:0] code(input int ch);
		return dac_code_o[12*ch +: 12];
	endfunction : code
	task automatic t_reset;
		`CK({gp_ctl_o, pd_pin_o, dac_code_o}, {GP_CTL_RST, PD_CFG_RST, 96'h0})
	endtask : t_reset
	task automatic t_ranges;
		wr(16'h1830);
		`CK({adc_range_o, dac_range_o, gp_ctl_o}, {2'b11, 16'h0030})
		wr(16'h1810);
		`CK({adc_range_o, dac_range_o}, 2'b01)
	endtask : t_ranges
	task automatic t_buffer;
		wr(16'h1900);
		`CK(adc_buf_pwr_o, 1'b1)
		wr(16'h1b00);
		`CK(adc_buf_pwr_o, 1'b0)
		conv_active_i = 1'b1;
		repeat (2) @(posedge clk_i);
		#2 `CK(adc_buf_pwr_o, 1'b1)
		conv_active_i = 1'b0;
		repeat (2) @(posedge clk_i);
		#2 `CK(adc_buf_pwr_o, 1'b0)
		wr(16'h1800);
	endtask : t_buffer
	task automatic t_pins;
		wr(16'h2011);
		wr(16'h4022);
		wr(16'h5044);
		wr(16'h6088);
		wr(16'h6881);
		`CK({adc_pin_o, gpo_pin_o, gpi_pin_o, od_pin_o, tri_pin_o}, 40'h1122448881)
	endtask : t_pins
	task automatic t_lock;
		wr(16'h2803);
		wr(16'h1880);
		wr(16'h28ff);
		wr(16'h30f0);
		`CK({dac_pin_o, pd_pin_o}, 16'h03ff)
		wr(16'h20ff);
		wr(16'h68ff);
		`CK({adc_pin_o, tri_pin_o}, 16'h1181)
		wr(16'h1800);
		wr(16'h3000);
		`CK(pd_pin_o, 8'h00)
	endtask : t_lock
	task automatic t_dac;
		wr(16'h9abc);
		`CK({code(1), dac_in_o[23:12], code(0)}, 36'habcabc000)
		wr(16'h1840);
		wr(16'ha123);
		`CK({code(0), code(1), code(2)}, 36'h123123000)
		wr(16'h1800);
	endtask : t_dac
	task automatic t_hold;
		wr(16'h3801);
		wr(16'h8555);
		`CK({dac_in_o[11:0], code(0), load_mode_o}, {24'h555123, 2'b01})
		wr(16'h3802);
		`CK({code(0), load_mode_o}, {12'h555, 2'b01})
		wr(16'h3800);
		wr(16'hf777);
		`CK(code(7), 12'h777)
	endtask : t_hold
	// Cut frames, unused load code and unused addresses must leave state alone
	task automatic t_refuse;
		wr(16'h1830, 8);
		`CK(gp_ctl_o, 16'h0000)
		wr(16'h1810);
		`CK(gp_ctl_o, 16'h0010)
		wr(16'h3803);
		`CK(load_mode_o, 2'b00)
		wr(16'h48ff);
		`CK({adc_pin_o, gpo_pin_o, gpi_pin_o, od_pin_o, tri_pin_o}, 40'h1122448881)
		wr(16'h1800);
	endtask : t_refuse
	task automatic stop_test;
		$display("Compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test
	initial begin
		repeat (100000) @(posedge clk_i);
		fails++;
		stop_test();
	end
	// Reset rises after time zero so the link receiver sees a real edge
	initial begin
		#1 sys_rst_i = 1'b1;
		repeat (12) @(posedge clk_i);
		#2 sys_rst_i = 1'b0;
		t_reset();
		t_ranges();
		t_buffer();
		t_pins();
		t_lock();
		t_dac();
		t_hold();
		t_refuse();
		sys_rst_i = 1'b1;
		repeat (2) @(posedge clk_i);
		#2 sys_rst_i = 1'b0;
		t_reset();
		t_ranges();
		stop_test();
	end
endmodule : test_general_control_and_dac_write
`default_nettype wire
